// ==== pkg/lcdl_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Pins between the timing controller / processor and the column loader
interface lcdl_if;
  // Parallel video side
  logic [9:0] video_word;
  logic sequence_start_flag;
  logic load_direction;
  logic edge_select;
  logic transfer_strobe;
  logic polarity_invert;
  // Serial side
  logic serial_frame_enable;
  logic serial_clock;
  logic serial_data_in;
  // Strap
  logic test_mode_select;
  modport device (
    input video_word, sequence_start_flag, load_direction, edge_select,
    input transfer_strobe, polarity_invert,
    input serial_frame_enable, serial_clock, serial_data_in,
    input test_mode_select
  );
  modport host (
    output video_word, sequence_start_flag, load_direction, edge_select,
    output transfer_strobe, polarity_invert,
    output serial_frame_enable, serial_clock, serial_data_in,
    output test_mode_select
  );
endinterface
`default_nettype wire

// ==== pkg/lcdl_pkg.sv ====
package lcdl_pkg;
  // Width of one column code
  localparam int CODE_W = 10;
  // Number of channel latches
  localparam int NUM_CH = 6;
  // Channel index width
  localparam int CH_W = 3;
  // First and last channel index
  localparam logic [2:0] CH_FIRST = 3'h0;
  localparam logic [2:0] CH_LAST = 3'h5;
  // Serial word length and field positions
  localparam int SER_W = 12;
  localparam logic [3:0] SER_LEN = 4'hc;
  localparam int SEL_HI_POS = 11;
  localparam int SEL_LO_POS = 10;
  localparam int AUX_W = 8;
  // Action codes on bits 11 and 10
  localparam logic [1:0] ACT_LOAD_TWO = 2'h0;
  localparam logic [1:0] ACT_RELEASE = 2'h1;
  localparam logic [1:0] ACT_LOAD_ONE = 2'h2;
  localparam logic [1:0] ACT_GROUND = 2'h3;
  // Polarity latency in clocks, inside the documented six to twelve
  localparam int INV_LAT = 6;
  // Depth of the aux command FIFO in the host
  localparam int FIFO_DEPTH = 4;
  // Host serial clock divider (terminal count; half period is four sys_clk cycles)
  localparam logic [1:0] SCLK_DIV = 2'h3;
  // Reset values
  localparam logic [7:0] AUX_RESET = 8'h00;
  localparam logic [9:0] CODE_RESET = 10'h000;
endpackage

// ==== sim/lcd_column_dac_loader_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcd_column_dac_loader_tb;
  // Clock, reset and tallies
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  int n_fail = 0;
  int n_tests = 0;
  // Host user side
  logic line_valid = 1'b0;
  logic line_ready;
  logic [59:0] line_words = 60'h0;
  logic line_reverse = 1'b0;
  logic line_rising = 1'b1;
  logic line_invert = 1'b0;
  logic line_transfer = 1'b0;
  logic test_mode = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  logic [11:0] cmd_word = 12'h000;
  logic cmd_busy;
  // Device outputs
  logic [59:0] video_code;
  logic video_invert;
  logic video_grounded;
  logic [7:0] aux_one_code;
  logic [7:0] aux_two_code;
  logic aux_one_grounded;
  lcdl_if link_i ();
  lcdl_host u_lcdl_host (.sys_clk, .reset_n, .link(link_i.host),
    .line_valid, .line_ready, .line_words, .line_reverse, .line_rising,
    .line_invert, .line_transfer, .test_mode, .cmd_valid, .cmd_ready,
    .cmd_word, .cmd_busy);
  lcdl_device u_lcdl_device (.sys_clk, .reset_n, .link(link_i.device),
    .video_code, .video_invert, .video_grounded, .aux_one_code,
    .aux_two_code, .aux_one_grounded);
  lcdl_monitor mon (.sys_clk, .reset_n,
    .sequence_start_flag(link_i.sequence_start_flag),
    .load_direction(link_i.load_direction),
    .edge_select(link_i.edge_select),
    .transfer_strobe(link_i.transfer_strobe),
    .serial_frame_enable(link_i.serial_frame_enable),
    .serial_clock(link_i.serial_clock),
    .serial_data_in(link_i.serial_data_in));
  // Free running clock
  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Count and report a mismatch
  task bad(input string m);
    n_fail++;
    n_tests++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  // Print the counts and the verdict
  task close_out;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Move to just after a later rising edge
  task step(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  // Offer one line and hold it until taken
  task send_line(input logic [59:0] w, input logic rv, rs, iv, xf, tm);
    int i;
    {line_words, line_reverse, line_rising} = {w, rv, rs};
    {line_invert, line_transfer, test_mode} = {iv, xf, tm};
    line_valid = 1'b1;
    i = 0;
    while (line_ready !== 1'b1 && i < 100)
    begin
      step(1);
      i++;
    end
    step(1);
    line_valid = 1'b0;
  endtask
  // Push one serial command and wait for its frame to finish
  task send_cmd(input logic [11:0] c);
    int i;
    cmd_word = c;
    cmd_valid = 1'b1;
    i = 0;
    while (cmd_ready !== 1'b1 && i < 100)
    begin
      step(1);
      i++;
    end
    step(1);
    cmd_valid = 1'b0;
    for (i = 0; i < 20 && cmd_busy !== 1'b1; i++)
      step(1);
    for (i = 0; i < 300 && cmd_busy !== 1'b0; i++)
      step(1);
    step(6);
  endtask
  // Load one line and wait for the output stage
  task t_load(input logic [9:0] b, input logic rv, rs);
    logic [59:0] w;
    logic [59:0] e;
    int i;
    for (i = 0; i < 6; i++)
    begin
      w[10*i+:10] = b + 10'(i);
      e[10*(rv ? 5 - i : i)+:10] = b + 10'(i);
    end
    send_line(w, rv, rs, 1'b0, 1'b1, 1'b0);
    for (i = 0; i < 40 && video_code !== e; i++)
      step(1);
    if (video_code !== e) bad("video codes");
    else n_tests++;
    $display("load test done");
  endtask
  // Without the strobe the outputs keep their codes
  task t_hold;
    logic [59:0] old;
    old = video_code;
    send_line(60'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    step(30);
    if (video_code !== old) bad("moved without strobe");
    else n_tests++;
    $display("hold test done");
  endtask
  // Invert reaches the outputs a fixed latency late
  task t_invert;
    int i;
    int j;
    send_line(60'h0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    for (i = 0; i < 50 && link_i.polarity_invert !== 1'b1; i++)
      step(1);
    for (j = 0; j < 50 && video_invert !== 1'b1; j++)
      step(1);
    if (j != lcdl_pkg::INV_LAT) bad("invert latency");
    else n_tests++;
    $display("invert test done");
  endtask
  // Every action code in turn, ignored bits set in three
  task t_serial;
    logic [11:0] cw [7] = '{12'h0a5, 12'hc77, 12'h05a, 12'hb3c, 12'hc00,
      12'h4e1, 12'hc00};
    logic [16:0] ex [7] = '{17'h0014a, 17'h0014b, 17'h000b5, 17'h078b4,
      17'h078b5, 17'h078b4, 17'h078b5};
    int k;
    for (k = 0; k < 7; k++)
    begin
      send_cmd(cw[k]);
      if ({aux_one_code, aux_two_code, video_grounded} !== ex[k] ||
        aux_one_grounded !== ex[k][0]) bad("serial action");
      else n_tests++;
    end
    $display("serial test done");
  endtask
  // Test mode overrides grounding, and grounding returns after
  task t_test_mode;
    send_line(60'h0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
    step(10);
    if (video_grounded !== 1'b0 || aux_one_grounded !== 1'b0)
      bad("test mode");
    else n_tests++;
    send_line(60'h0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    step(10);
    if (video_grounded !== 1'b1 || aux_one_grounded !== 1'b1)
      bad("grounded mode");
    else n_tests++;
    send_cmd(12'h400);
    $display("test mode test done");
  endtask
  // Fill the command buffer until refused, then drain it
  task t_fifo;
    int k;
    int i;
    k = 0;
    cmd_word = 12'h010;
    cmd_valid = 1'b1;
    while (cmd_ready === 1'b1 && k < 8)
    begin
      step(1);
      k++;
      cmd_word = 12'h010 + 12'(k);
    end
    cmd_valid = 1'b0;
    if (k < lcdl_pkg::FIFO_DEPTH || k > 6) bad("buffer depth");
    else n_tests++;
    for (i = 0; i < 3000 && aux_two_code !== 8'(12'h00f + 12'(k)); i++)
      step(1);
    if (aux_two_code !== 8'(12'h00f + 12'(k))) bad("drain");
    else n_tests++;
    $display("buffer test done");
  endtask
  // Grounding is the first step before the supplies go
  task t_power_down;
    send_cmd(12'hc00);
    if (video_grounded !== 1'b1 || aux_one_grounded !== 1'b1)
      bad("power-down grounding");
    else n_tests++;
    $display("power down test done");
  endtask
  // Cut a hang short
  initial
  begin
    #1000000;
    bad("watchdog");
    close_out;
  end
  // Main sequence
  initial
  begin
    repeat (16) @(posedge sys_clk);
    #2;
    reset_n = 1'b1;
    step(1);
    if (video_code !== 60'h0 || aux_two_code !== 8'h00) bad("reset");
    else n_tests++;
    t_load(10'h3a1, 1'b0, 1'b1);
    t_load(10'h2f0, 1'b1, 1'b1);
    t_load(10'h155, 1'b1, 1'b0);
    t_load(10'h3fa, 1'b0, 1'b0);
    t_hold;
    t_invert;
    t_serial;
    t_test_mode;
    t_fifo;
    t_power_down;
    close_out;
  end
endmodule
`default_nettype wire

// ==== sim/lcdl_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// Watches the pins between the two ends
module lcdl_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Parallel control pins
  input wire logic sequence_start_flag,
  input wire logic load_direction,
  input wire logic edge_select,
  input wire logic transfer_strobe,
  // Serial pins
  input wire logic serial_frame_enable,
  input wire logic serial_clock,
  input wire logic serial_data_in
);
  // Serial clock seen last cycle
  logic sclk_reg;
  // Rising serial clocks in the open frame
  logic [4:0] bits_reg;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Delay the serial clock by one cycle
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      sclk_reg <= 1'b0;
    else
      sclk_reg <= serial_clock;
  // Count rising serial clocks, clear between frames
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      bits_reg <= 5'h00;
    else if (!serial_frame_enable)
      bits_reg <= 5'h00;
    else if (serial_clock && !sclk_reg)
      bits_reg <= bits_reg + 5'h01;
  a_flag_one_cycle: assert property (
    $rose(sequence_start_flag) |=> !sequence_start_flag)
    else $error("start flag longer than one cycle");
  a_strobe_one_cycle: assert property (
    $rose(transfer_strobe) |=> !transfer_strobe)
    else $error("strobe longer than one cycle");
  a_strobe_after_flag: assert property (
    $rose(transfer_strobe) |-> $past(sequence_start_flag, 6))
    else $error("strobe not six cycles after flag");
  a_mode_held_load: assert property (
    $rose(sequence_start_flag) |=>
      ($stable(load_direction) && $stable(edge_select)) [*6])
    else $error("direction or edge changed in a load");
  a_sclk_high_len: assert property (
    $rose(serial_clock) |-> serial_clock [*4] ##1 !serial_clock)
    else $error("serial clock high time wrong");
  a_sdi_stable_high: assert property (
    serial_clock && $past(serial_clock) |-> $stable(serial_data_in))
    else $error("serial data moved while clock high");
  a_sclk_in_frame: assert property (
    $rose(serial_clock) |-> serial_frame_enable)
    else $error("serial clock outside a frame");
  a_frame_twelve_bits: assert property (
    $fell(serial_frame_enable) |-> bits_reg == 5'h0c)
    else $error("frame not twelve bits");
endmodule
`default_nettype wire

// ==== src/lcdl_device.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcdl_device (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Link
  lcdl_if.device link,
  // Output stage codes, six packed channels
  output logic [59:0] video_code,
  output logic video_invert,
  output logic video_grounded,
  // Auxiliary DAC codes
  output logic [7:0] aux_one_code,
  output logic [7:0] aux_two_code,
  output logic aux_one_grounded
);
  // Negative-edge samples of the parallel bus
  logic [9:0] neg_word_reg;
  logic neg_sequence_start_flag_reg;
  logic neg_dir_reg;
  // Selected samples for this cycle
  logic [9:0] s_word;
  logic s_sequence_start_flag;
  logic s_dir;
  // Loader state
  logic sequence_start_flag_d_reg;
  logic xfr_d_reg;
  logic loading_reg;
  logic [2:0] ch_reg;
  logic dir_hold_reg;
  logic [9:0] latch_reg [6];
  // Invert pipeline
  logic [5:0] inv_pipe_reg;
  // Serial synchronisers, three stages each
  logic [2:0] sen_sync_reg;
  logic [2:0] sclk_sync_reg;
  logic [2:0] sdi_sync_reg;
  logic sclk_rise;
  logic sen_fall;
  logic [11:0] ser_shift_reg;
  logic [4:0] ser_cnt_reg;
  logic ground_reg;

  // Falling-edge capture, in place of a second load edge
  always_ff @(negedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      neg_word_reg <= lcdl_pkg::CODE_RESET;
      neg_sequence_start_flag_reg <= 1'b0;
      neg_dir_reg <= 1'b0;
    end
    else
    begin
      neg_word_reg <= link.video_word;
      neg_sequence_start_flag_reg <= link.sequence_start_flag;
      neg_dir_reg <= link.load_direction;
    end
  end

  // Pick the edge that carries the sample
  assign s_word = link.edge_select ? link.video_word : neg_word_reg;
  assign s_sequence_start_flag = link.edge_select ? link.sequence_start_flag : neg_sequence_start_flag_reg;
  assign s_dir = link.edge_select ? link.load_direction : neg_dir_reg;

  // Flag from previous edge opens a six-word load
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sequence_start_flag_d_reg <= 1'b0;
      loading_reg <= 1'b0;
      ch_reg <= lcdl_pkg::CH_FIRST;
      dir_hold_reg <= 1'b0;
    end
    else
    begin
      sequence_start_flag_d_reg <= s_sequence_start_flag;
      if (sequence_start_flag_d_reg)
      begin
        // Restart: channel after the first one is next
        loading_reg <= 1'b1;
        dir_hold_reg <= s_dir;
        ch_reg <= s_dir ? lcdl_pkg::CH_LAST - 3'h1 : lcdl_pkg::CH_FIRST + 3'h1;
      end
      else if (loading_reg)
      begin
        if (ch_reg == (dir_hold_reg ? lcdl_pkg::CH_FIRST : lcdl_pkg::CH_LAST))
        begin
          loading_reg <= 1'b0;
        end
        ch_reg <= dir_hold_reg ? ch_reg - 3'h1 : ch_reg + 3'h1;
      end
    end
  end

  // Word goes to the channel in turn
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < lcdl_pkg::NUM_CH; i++)
      begin
        latch_reg[i] <= lcdl_pkg::CODE_RESET;
      end
    end
    else if (sequence_start_flag_d_reg)
    begin
      latch_reg[s_dir ? lcdl_pkg::CH_LAST : lcdl_pkg::CH_FIRST] <= s_word;
    end
    else if (loading_reg)
    begin
      latch_reg[ch_reg] <= s_word;
    end
  end

  // Strobe seen one rising edge ahead moves all six out
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      xfr_d_reg <= 1'b0;
      video_code <= '0;
    end
    else
    begin
      xfr_d_reg <= link.transfer_strobe;
      if (xfr_d_reg)
      begin
        for (int i = 0; i < lcdl_pkg::NUM_CH; i++)
        begin
          video_code[i*10 +: 10] <= latch_reg[i];
        end
      end
    end
  end

  // Invert flag delayed by a fixed six clocks
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      inv_pipe_reg <= '0;
      video_invert <= 1'b0;
    end
    else
    begin
      inv_pipe_reg <= {inv_pipe_reg[4:0], link.polarity_invert};
      video_invert <= inv_pipe_reg[lcdl_pkg::INV_LAT-2];
    end
  end

  // Three-stage synchronisers on the serial pins
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sen_sync_reg <= '0;
      sclk_sync_reg <= '0;
      sdi_sync_reg <= '0;
    end
    else
    begin
      sen_sync_reg <= {sen_sync_reg[1:0], link.serial_frame_enable};
      sclk_sync_reg <= {sclk_sync_reg[1:0], link.serial_clock};
      sdi_sync_reg <= {sdi_sync_reg[1:0], link.serial_data_in};
    end
  end
  assign sclk_rise = sclk_sync_reg[1] && !sclk_sync_reg[2];
  assign sen_fall = !sen_sync_reg[1] && sen_sync_reg[2];

  // Shift MSB first while the frame is open
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ser_shift_reg <= '0;
      ser_cnt_reg <= '0;
    end
    else if (!sen_sync_reg[2])
    begin
      ser_cnt_reg <= '0;
    end
    else if (sclk_rise)
    begin
      ser_shift_reg <= {ser_shift_reg[10:0], sdi_sync_reg[2]};
      if (ser_cnt_reg != 5'h1f)
      begin
        ser_cnt_reg <= ser_cnt_reg + 5'h01;
      end
    end
  end

  // Decode on frame close; only full frames act
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aux_one_code <= lcdl_pkg::AUX_RESET;
      aux_two_code <= lcdl_pkg::AUX_RESET;
      ground_reg <= 1'b0;
    end
    else if (sen_fall && ser_cnt_reg >= 5'(lcdl_pkg::SER_LEN))
    begin
      unique case (ser_shift_reg[lcdl_pkg::SEL_HI_POS:lcdl_pkg::SEL_LO_POS])
        lcdl_pkg::ACT_LOAD_TWO:
        begin
          aux_two_code <= ser_shift_reg[7:0];
        end
        lcdl_pkg::ACT_LOAD_ONE:
        begin
          aux_one_code <= ser_shift_reg[7:0];
          ground_reg <= 1'b0;
        end
        lcdl_pkg::ACT_RELEASE:
        begin
          ground_reg <= 1'b0;
        end
        lcdl_pkg::ACT_GROUND:
        begin
          ground_reg <= 1'b1;
        end
      endcase
    end
  end

  // Test mode overrides grounding of video and aux one
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      video_grounded <= 1'b0;
      aux_one_grounded <= 1'b0;
    end
    else
    begin
      video_grounded <= ground_reg && !link.test_mode_select;
      aux_one_grounded <= ground_reg && !link.test_mode_select;
    end
  end
endmodule
`default_nettype wire

// ==== src/lcdl_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
// Small valid/ready FIFO
module lcdl_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // Storage array
  logic [WIDTH-1:0] mem_reg [DEPTH];
  // Pointers and fill count
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  // Honest full and empty
  assign in_ready = (count_reg != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Write into storage
  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointer and count upkeep
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== src/lcdl_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// Timing controller and serial master end
module lcdl_host (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Link
  lcdl_if.host link,
  // Line request: six words, fill order, edge, polarity
  input wire logic line_valid,
  output logic line_ready,
  input wire logic [59:0] line_words,
  input wire logic line_reverse,
  input wire logic line_rising,
  input wire logic line_invert,
  input wire logic line_transfer,
  input wire logic test_mode,
  // Serial command request
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [11:0] cmd_word,
  output logic cmd_busy
);
  // Video sender state
  logic [59:0] words_reg;
  logic [2:0] vcnt_reg;
  logic vbusy_reg;
  logic [9:0] vword_reg;
  logic sequence_start_flag_reg;
  logic xfr_reg;
  logic dir_reg;
  logic edge_reg;
  logic inv_reg;
  logic tm_reg;
  // Serial sender state
  logic fifo_valid;
  logic fifo_take;
  logic [11:0] fifo_word;
  logic [11:0] shift_reg;
  logic [3:0] bits_reg;
  logic sbusy_reg;
  logic sen_reg;
  logic sclk_reg;
  logic [1:0] div_reg;
  logic tick;

  assign line_ready = !vbusy_reg;
  assign cmd_busy = sbusy_reg;
  assign link.video_word = vword_reg;
  assign link.sequence_start_flag = sequence_start_flag_reg;
  assign link.transfer_strobe = xfr_reg;
  assign link.load_direction = dir_reg;
  assign link.edge_select = edge_reg;
  assign link.polarity_invert = inv_reg;
  assign link.test_mode_select = tm_reg;
  assign link.serial_frame_enable = sen_reg;
  assign link.serial_clock = sclk_reg;
  assign link.serial_data_in = shift_reg[11];

  // Flag one cycle ahead, then six words, transfer strobe with the sixth
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      words_reg <= '0;
      vcnt_reg <= '0;
      vbusy_reg <= 1'b0;
      vword_reg <= lcdl_pkg::CODE_RESET;
      sequence_start_flag_reg <= 1'b0;
      xfr_reg <= 1'b0;
      dir_reg <= 1'b0;
      edge_reg <= 1'b1;
      inv_reg <= 1'b0;
      tm_reg <= 1'b0;
    end
    else
    begin
      tm_reg <= test_mode;
      xfr_reg <= 1'b0;
      sequence_start_flag_reg <= 1'b0;
      if (!vbusy_reg && line_valid)
      begin
        words_reg <= line_words;
        dir_reg <= line_reverse;
        edge_reg <= line_rising;
        inv_reg <= line_invert;
        sequence_start_flag_reg <= 1'b1;
        vbusy_reg <= 1'b1;
        vcnt_reg <= '0;
      end
      else if (vbusy_reg)
      begin
        // Word k of the line goes out in slot k
        vword_reg <= words_reg[9:0];
        words_reg <= {10'h000, words_reg[59:10]};
        if (vcnt_reg == lcdl_pkg::CH_LAST)
        begin
          vbusy_reg <= 1'b0;
          xfr_reg <= line_transfer;
        end
        else
        begin
          vcnt_reg <= vcnt_reg + 1'b1;
        end
      end
    end
  end

  // Aux commands queue up before the slow serial port
  lcdl_fifo #(.WIDTH(lcdl_pkg::SER_W), .DEPTH(lcdl_pkg::FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .in_valid(cmd_valid),
    .in_ready(cmd_ready),
    .in_data(cmd_word),
    .out_valid(fifo_valid),
    .out_ready(fifo_take),
    .out_data(fifo_word)
  );
  assign fifo_take = !sbusy_reg;

  // Serial clock enable divider
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_reg <= '0;
    end
    else
    begin
      div_reg <= (div_reg == lcdl_pkg::SCLK_DIV) ? '0 : div_reg + 1'b1;
    end
  end
  assign tick = (div_reg == lcdl_pkg::SCLK_DIV);

  // Twelve bits MSB first, frame closes to execute
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shift_reg <= '0;
      bits_reg <= '0;
      sbusy_reg <= 1'b0;
      sen_reg <= 1'b0;
      sclk_reg <= 1'b0;
    end
    else if (!sbusy_reg)
    begin
      if (fifo_valid)
      begin
        shift_reg <= fifo_word;
        bits_reg <= '0;
        sbusy_reg <= 1'b1;
        sen_reg <= 1'b1;
      end
    end
    else if (tick)
    begin
      if (bits_reg == lcdl_pkg::SER_LEN)
      begin
        // Frame end executes the command
        sen_reg <= 1'b0;
        sbusy_reg <= 1'b0;
      end
      else if (!sclk_reg)
      begin
        sclk_reg <= 1'b1;
      end
      else
      begin
        sclk_reg <= 1'b0;
        shift_reg <= {shift_reg[10:0], 1'b0};
        bits_reg <= bits_reg + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire
